//--- logic/synth_cfg_pkg.sv
package synth_cfg_pkg;
    // shift register and field layout
    localparam int SR_LEN = 14;
    localparam int LOOP_W = 9;
    localparam int POST_W = 2;
    localparam int MON_W = 3;
    localparam int SR_MON_LSB = 11;
    localparam int SR_POST_LSB = 9;
    localparam int SR_LOOP_LSB = 0;
    localparam int SR_LAST_BIT = 13;

    // reference divider: toggle every half of the ratio eight
    localparam int REF_DIV_RATIO = 8;
    localparam logic [1:0] REF_HALF_LAST = 2'(REF_DIV_RATIO / 2 - 1);

    // post divider select codes
    localparam logic [1:0] POST_DIV2 = 2'h0;
    localparam logic [1:0] POST_DIV4 = 2'h1;
    localparam logic [1:0] POST_DIV8 = 2'h2;
    localparam logic [1:0] POST_DIV1 = 2'h3;
    // half-period counts, minus one, in source rising edges
    localparam logic [1:0] HALF_LAST_DIV2 = 2'h0;
    localparam logic [1:0] HALF_LAST_DIV4 = 2'h1;
    localparam logic [1:0] HALF_LAST_DIV8 = 2'h3;

    // monitor select codes
    localparam logic [2:0] MON_LAST_SR = 3'h0;
    localparam logic [2:0] MON_HIGH = 3'h1;
    localparam logic [2:0] MON_REF = 3'h2;
    localparam logic [2:0] MON_LOOP = 3'h3;
    localparam logic [2:0] MON_SYNTH = 3'h4;
    localparam logic [2:0] MON_LOW = 3'h5;
    localparam logic [2:0] MON_BYPASS = 3'h6;
    localparam logic [2:0] MON_SYNTH_DIV4 = 3'h7;

    // configuration latch reset values
    localparam logic [8:0] LOOP_RESET = 9'h1FF;
    localparam logic [1:0] POST_RESET = 2'h3;
    localparam logic [2:0] MON_RESET = 3'h0;
    localparam logic [2:0] MON_PRESET = 3'h0;

    // apb register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CFG = 8'h04;
    localparam logic [7:0] ADDR_SHIFT = 8'h08;
    localparam int CTRL_RUN_BIT = 0;
    localparam logic CTRL_RUN_RESET = 1'b1;
    localparam int CFG_MON_LSB = 11;
    localparam int CFG_POST_LSB = 9;
    localparam int CFG_LOOP_LSB = 0;
endpackage : synth_cfg_pkg

//--- logic/synth_divider_config_logic.sv
// How it works
// - crystal oscillator divided by eight gives reference
// - feedback divider counts vco edges by loop value
// - loop value is plain unsigned binary ratio
// - post select 00/01/10/11 gives 2/4/8/1
// - post divider output has fifty percent duty
// - serial configuration shift register is fourteen bits
// - each shift clock rise samples and shifts once
// - latches follow shift register while serial strobe high
// - latches follow pins while parallel strobe low
// - parallel load wins over serial load
// - serial transfer only while parallel strobe high
// - undriven divider pins read as one
// - monitor select bits choose monitor output node
// - stream order monitor, post, loop, msb first
// - parallel strobe low presets monitor select zero
// - monitor mux order for codes 000 to 111
// - code 110 bypasses pll with shift clock
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module synth_divider_config_logic (
    input wire logic clk, // 25 MHz system clock
    input wire logic reset_n, // asynchronous reset, active low
    input wire logic osc_level, // crystal oscillator level, same clock domain
    input wire logic vco_level, // vco level, same clock domain
    input wire logic serial_shift_clk, // serial shift clock pin
    input wire logic serial_in, // serial data pin
    input wire logic serial_latch_strobe, // serial load strobe pin
    input wire logic parallel_latch_strobe_n, // parallel load strobe pin, low active
    input wire logic [synth_cfg_pkg::LOOP_W-1:0] loop_div_pins, // parallel loop value pins
    input wire logic [synth_cfg_pkg::LOOP_W-1:0] loop_div_pins_driven, // 1 where driven
    input wire logic [synth_cfg_pkg::POST_W-1:0] post_div_pins, // parallel post select pins
    input wire logic [synth_cfg_pkg::POST_W-1:0] post_div_pins_driven, // 1 where driven
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    output logic ref_clock_div, // reference to phase comparison
    output logic loop_div_out, // loop divider output to phase comparison
    output logic synth_out, // synthesizer output
    output logic monitor_out // monitor output
);
    import synth_cfg_pkg::*;

    localparam int SYNC_W = 3 + 2 * LOOP_W + 2 * POST_W + 1;

    // two-stage synchroniser for every pin input
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    wire [SYNC_W-1:0] pins_raw = {serial_shift_clk, serial_in, serial_latch_strobe,
                                  loop_div_pins, loop_div_pins_driven,
                                  post_div_pins, post_div_pins_driven,
                                  parallel_latch_strobe_n};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
        end
    end

    wire sclk_s = sync2_q[SYNC_W-1];
    wire sdata_s = sync2_q[SYNC_W-2];
    wire sload_s = sync2_q[SYNC_W-3];
    wire [LOOP_W-1:0] loop_pin_s = sync2_q[2*LOOP_W+2*POST_W:LOOP_W+2*POST_W+1];
    wire [LOOP_W-1:0] loop_drv_s = sync2_q[LOOP_W+2*POST_W:2*POST_W+1];
    wire [POST_W-1:0] post_pin_s = sync2_q[2*POST_W:POST_W+1];
    wire [POST_W-1:0] post_drv_s = sync2_q[POST_W:1];
    wire pload_n_s = sync2_q[0];

    wire [LOOP_W-1:0] loop_pin_eff = loop_pin_s | ~loop_drv_s;
    wire [POST_W-1:0] post_pin_eff = post_pin_s | ~post_drv_s;

    // edge detection on the synchronised shift clock and on the same-domain osc, vco and output levels
    logic sclk_prev_q;
    logic osc_prev_q;
    logic vco_prev_q;
    logic synth_prev_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_prev_q <= 1'b0;
            osc_prev_q <= 1'b0;
            vco_prev_q <= 1'b0;
            synth_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
            osc_prev_q <= osc_level;
            vco_prev_q <= vco_level;
            synth_prev_q <= synth_out;
        end
    end

    wire sclk_rise = sclk_s & ~sclk_prev_q;
    wire osc_rise = osc_level & ~osc_prev_q;
    wire vco_rise = vco_level & ~vco_prev_q;
    wire synth_rise = synth_out & ~synth_prev_q;

    // serial shift register, first bit ends at the top
    logic [SR_LEN-1:0] shift_q;
    logic [SR_LEN-1:0] shift_d;
    assign shift_d = {shift_q[SR_LEN-2:0], sdata_s};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_q <= '0;
        end else if (sclk_rise) begin
            shift_q <= shift_d;
        end
    end

    // configuration latches, transparent while a load is active
    logic [LOOP_W-1:0] loop_q;
    logic [POST_W-1:0] post_q;
    logic [MON_W-1:0] mon_q;
    wire par_load = ~pload_n_s;
    wire ser_load = pload_n_s & sload_s;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            loop_q <= LOOP_RESET;
            post_q <= POST_RESET;
            mon_q <= MON_RESET;
        end else if (par_load) begin
            loop_q <= loop_pin_eff;
            post_q <= post_pin_eff;
            mon_q <= MON_PRESET;
        end else if (ser_load) begin
            loop_q <= shift_q[SR_LOOP_LSB +: LOOP_W];
            post_q <= shift_q[SR_POST_LSB +: POST_W];
            mon_q <= shift_q[SR_MON_LSB +: MON_W];
        end
    end

    // software control: run bit holds every divider cleared when low
    logic run_q;
    wire run = run_q;

    // bypass routes the shift clock into both dividers
    wire bypass = (mon_q == MON_BYPASS);
    wire src_rise = bypass ? sclk_rise : vco_rise;
    wire src_level = bypass ? sclk_s : vco_level;

    // reference divider
    logic [1:0] ref_cnt_q;
    logic ref_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_cnt_q <= '0;
            ref_q <= 1'b0;
        end else if (!run) begin
            ref_cnt_q <= '0;
            ref_q <= 1'b0;
        end else if (osc_rise) begin
            if (ref_cnt_q == REF_HALF_LAST) begin
                ref_cnt_q <= '0;
                ref_q <= ~ref_q;
            end else begin
                ref_cnt_q <= ref_cnt_q + 2'h1;
            end
        end
    end

    // loop divider: one source period high per loop_q source periods
    logic [LOOP_W-1:0] loop_cnt_q;
    logic loop_out_q;
    wire [LOOP_W-1:0] loop_last = (loop_q == '0) ? '0 : loop_q - 9'h001;
    wire loop_term = (loop_cnt_q >= loop_last);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            loop_cnt_q <= '0;
            loop_out_q <= 1'b0;
        end else if (!run) begin
            loop_cnt_q <= '0;
            loop_out_q <= 1'b0;
        end else if (src_rise) begin
            loop_cnt_q <= loop_term ? '0 : loop_cnt_q + 9'h001;
            loop_out_q <= loop_term;
        end
    end

    // post divider: toggling keeps the duty at one half
    logic [1:0] post_cnt_q;
    logic post_tog_q;
    logic synth_q;
    logic [1:0] half_last;
    assign half_last = (post_q == POST_DIV2) ? HALF_LAST_DIV2 :
                       (post_q == POST_DIV4) ? HALF_LAST_DIV4 : HALF_LAST_DIV8;
    wire post_bypass = (post_q == POST_DIV1);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            post_cnt_q <= '0;
            post_tog_q <= 1'b0;
        end else if (!run) begin
            post_cnt_q <= '0;
            post_tog_q <= 1'b0;
        end else if (src_rise) begin
            if (post_cnt_q >= half_last) begin
                post_cnt_q <= '0;
                post_tog_q <= ~post_tog_q;
            end else begin
                post_cnt_q <= post_cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            synth_q <= 1'b0;
        end else begin
            synth_q <= post_bypass ? (run & src_level) : post_tog_q;
        end
    end

    // synth_out divided by four for the monitor
    logic div4_cnt_q;
    logic div4_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div4_cnt_q <= 1'b0;
            div4_q <= 1'b0;
        end else if (!run) begin
            div4_cnt_q <= 1'b0;
            div4_q <= 1'b0;
        end else if (synth_rise) begin
            div4_cnt_q <= ~div4_cnt_q;
            if (div4_cnt_q) begin
                div4_q <= ~div4_q;
            end
        end
    end

    // monitor multiplexer
    logic mon_d;
    logic mon_out_q;
    always_comb begin
        unique case (mon_q)
            MON_LAST_SR: mon_d = shift_q[SR_LAST_BIT];
            MON_HIGH: mon_d = 1'b1;
            MON_REF: mon_d = ref_q;
            MON_LOOP: mon_d = loop_out_q;
            MON_SYNTH: mon_d = synth_q;
            MON_LOW: mon_d = 1'b0;
            MON_BYPASS: mon_d = loop_out_q;
            MON_SYNTH_DIV4: mon_d = div4_q;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mon_out_q <= 1'b0;
        end else begin
            mon_out_q <= mon_d;
        end
    end

    assign ref_clock_div = ref_q;
    assign loop_div_out = loop_out_q;
    assign synth_out = synth_q;
    assign monitor_out = mon_out_q;

    // apb slave, zero wait states, read data captured in setup
    wire sel_ctrl = (paddr == ADDR_CTRL);
    wire sel_cfg = (paddr == ADDR_CFG);
    wire sel_shift = (paddr == ADDR_SHIFT);
    wire mapped = sel_ctrl | sel_cfg | sel_shift;
    wire setup = psel & ~penable;
    wire wr_ctrl = psel & penable & pwrite & sel_ctrl;
    wire [31:0] cfg_word = {18'h0, mon_q, post_q, loop_q};
    wire [31:0] rd_mux = sel_ctrl ? {31'h0, run_q} :
                         sel_cfg ? cfg_word :
                         sel_shift ? {18'h0, shift_q} : 32'h0;
    logic [31:0] prdata_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            run_q <= CTRL_RUN_RESET;
            prdata_q <= 32'h0;
        end else begin
            if (wr_ctrl) begin
                run_q <= pwdata[CTRL_RUN_BIT];
            end
            if (setup) begin
                prdata_q <= pwrite ? 32'h0 : rd_mux;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
endmodule : synth_divider_config_logic
`default_nettype wire

//--- verif/host_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
    input wire logic clk, // clock
    output logic serial_shift_clk, // sclk
    output logic serial_in, // data
    output logic serial_latch_strobe // strobe
);
    initial {serial_shift_clk, serial_in, serial_latch_strobe} = 3'h0;
    // clock idles low between frames; data held a half period around each rise
    task automatic send(input logic [13:0] w, input int n, input int half);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk) serial_in <= w[i];
            repeat (half) @(posedge clk);
            serial_shift_clk <= 1'b1;
            repeat (half) @(posedge clk);
            serial_shift_clk <= 1'b0;
        end
        repeat (half) @(posedge clk);
        serial_in <= ~serial_in;
    endtask : send
    // no shifting while the strobe moves
    task automatic set_strobe(input logic v, input int half);
        @(posedge clk) serial_latch_strobe <= v;
        repeat (half) @(posedge clk);
    endtask : set_strobe
endmodule : host_link_model
`default_nettype wire

//--- verif/synth_divider_config_logic_sva.sv
`timescale 1ns/1ps
`default_nettype none
module synth_cfg_sva (
    input wire logic clk, // clock
    input wire logic reset_n, // reset
    input wire logic osc_level, // osc
    input wire logic vco_level, // vco
    input wire logic serial_shift_clk, // sclk
    input wire logic psel, // apb
    input wire logic penable, // apb
    input wire logic pwrite, // apb
    input wire logic [7:0] paddr, // apb
    input wire logic [31:0] pwdata, // apb
    input wire logic [31:0] prdata, // apb
    input wire logic pready, // apb
    input wire logic pslverr, // apb
    input wire logic ref_clock_div, // ref
    input wire logic loop_div_out, // loop
    input wire logic synth_out // out
);
    import synth_cfg_pkg::*;
    logic osc_q, ref_q, vco_q, sck_q;
    // run bit as last written over the bus
    logic run_m;
    logic [2:0] rise_q;
    logic [3:0] idle_q;
    wire logic acc = psel && penable;
    wire logic hit = paddr == ADDR_CTRL || paddr == ADDR_CFG || paddr == ADDR_SHIFT;
    wire logic orise = osc_level && !osc_q;
    // cycles since the last edge of either divider source
    wire logic sedge = vco_level != vco_q || serial_shift_clk != sck_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {osc_q, ref_q, vco_q, sck_q, rise_q, idle_q} <= '0;
            run_m <= CTRL_RUN_RESET;
        end else begin
            {osc_q, ref_q, vco_q, sck_q} <= {osc_level, ref_clock_div, vco_level, serial_shift_clk};
            if (acc && pwrite && paddr == ADDR_CTRL) begin
                run_m <= pwdata[CTRL_RUN_BIT];
            end
            rise_q <= run_m ? (ref_clock_div != ref_q ? 3'h0 : rise_q) + 3'(orise) : 3'h0;
            idle_q <= sedge ? 4'h0 : idle_q + 4'(idle_q != 4'hF);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_ready_high: assert property (pready) else $error("ready low");
    a_err_unmapped: assert property (acc && !hit |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped not refused");
    a_err_mapped: assert property (acc && hit |-> !pslverr) else $error("mapped refused");
    a_err_idle: assert property (!acc |-> !pslverr) else $error("error while idle");
    a_ref_half: assert property (run_m && $changed(ref_clock_div) |-> rise_q == 3'h4)
        else $error("ref half period wrong");
    a_ref_bound: assert property (rise_q < 3'h5) else $error("ref stuck");
    a_synth_cause: assert property ($changed(synth_out) |-> idle_q < 4'h6)
        else $error("out moved without source");
    a_loop_cause: assert property ($changed(loop_div_out) |-> idle_q < 4'h6)
        else $error("loop moved without source");
endmodule : synth_cfg_sva
bind synth_divider_config_logic synth_cfg_sva synth_cfg_sva_inst (.clk(clk), .reset_n(reset_n),
    .osc_level(osc_level), .vco_level(vco_level), .serial_shift_clk(serial_shift_clk),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_clock_div(ref_clock_div),
    .loop_div_out(loop_div_out), .synth_out(synth_out));
`default_nettype wire

//--- verif/tb_synth_divider_config_logic.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("FAIL %0t got %0h exp %0h", $time, g, e); end end
module tb_synth_divider_config_logic;
    import synth_cfg_pkg::*;
    logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pl_n = 0;
    logic osc_level = 0, vco_level = 0, err, syn_d = 0, mon_d = 0;
    logic [7:0] paddr = 8'h00, b;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [8:0] lp = 9'h000, lpd = 9'h000;
    logic [1:0] pp = 2'h0, ppd = 2'h0;
    logic [13:0] w;
    logic pready, pslverr, ref_clock_div, loop_div_out, synth_out, monitor_out, sck, sdi, sst;
    int err_count = 0, checked = 0, seed = 96860, cyc = 0, ph = 0, sel = 0;
    int per, hi, m_val, p_val, exp_cfg = 0, syn_chg = 0, mon_rise = 0, c0, c1;
    wire logic pick = sel == 0 ? synth_out : sel == 1 ? loop_div_out :
        sel == 2 ? ref_clock_div : monitor_out;
    synth_divider_config_logic synth_divider_config_logic_inst (.clk(clk), .reset_n(reset_n),
        .osc_level(osc_level), .vco_level(vco_level), .serial_shift_clk(sck), .serial_in(sdi),
        .serial_latch_strobe(sst), .parallel_latch_strobe_n(pl_n), .loop_div_pins(lp),
        .loop_div_pins_driven(lpd), .post_div_pins(pp), .post_div_pins_driven(ppd),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_clock_div(ref_clock_div),
        .loop_div_out(loop_div_out), .synth_out(synth_out), .monitor_out(monitor_out));
    host_link_model host_link_model_inst (.clk(clk), .serial_shift_clk(sck), .serial_in(sdi),
        .serial_latch_strobe(sst));
    always #20 clk = ~clk;
    // oscillator rises every 8 cycles, vco every 4
    always @(posedge clk) begin
        ph <= reset_n ? ph + 1 : 0;
        osc_level <= ph[2];
        vco_level <= ph[1];
        syn_d <= synth_out;
        mon_d <= monitor_out;
        syn_chg <= syn_chg + int'(synth_out !== syn_d);
        mon_rise <= mon_rise + int'(monitor_out && !mon_d);
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            give_verdict();
        end
    end
    function automatic int nd(input int p);
        return p == 0 ? 2 : p == 1 ? 4 : p == 2 ? 8 : 1;
    endfunction : nd
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        {err, rd} = {pslverr, prdata};
        {psel, penable} <= 2'h0;
    endtask : apb
    task automatic measure(input int s);
        int st;
        logic p;
        sel = s;
        st = 0;
        per = 0;
        hi = 0;
        p = 1'b1;
        for (int i = 0; i < 2000 && st < 2; i++) begin
            @(posedge clk);
            st += int'(pick && !p);
            if (st == 1) begin
                per++;
                hi += int'(pick);
            end
            p = pick;
        end
    endtask : measure
    task automatic pload(input int lv, pv, ld, pd, input bit both);
        if (both) host_link_model_inst.set_strobe(1'b1, 2);
        @(posedge clk);
        {lp, lpd, pp, ppd, pl_n} <= {9'(lv), 9'(ld), 2'(pv), 2'(pd), 1'b0};
        exp_cfg = ((pv | ~pd) & 3) << 9 | ((lv | ~ld) & 511);
        repeat (6) @(posedge clk);
        apb(1'b0, ADDR_CFG, 32'h0);
        `CHK(rd, 32'(exp_cfg))
        if (both) host_link_model_inst.set_strobe(1'b0, 2);
        @(posedge clk) pl_n <= 1'b1;
        repeat (4) @(posedge clk);
        apb(1'b0, ADDR_CFG, 32'h0);
        `CHK(rd, 32'(exp_cfg))
    endtask : pload
    task automatic give_verdict;
        $display("mismatches %0d comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk) pl_n <= 1'b1;
        apb(1'b1, ADDR_CTRL, 32'h1);
        apb(1'b1, ADDR_CFG, 32'h0);
        apb(1'b0, ADDR_CFG, 32'h0);
        `CHK(rd, 32'h7FF)
        apb(1'b0, 8'h0C, 32'h0);
        `CHK({err, rd}, 33'h100000000)
        for (int p = 0; p < 4; p++) begin
            m_val = 2 + ($random(seed) & 3);
            pload(m_val, p, 511, 3, 1'b0);
            measure(0);
            `CHK(per, 4 * nd(p))
            `CHK(hi, 2 * nd(p))
            measure(1);
            `CHK(per, 4 * m_val)
            measure(2);
            `CHK(per + hi, 96)
        end
        for (int t = 0; t < 8; t++) begin
            m_val = t == 6 ? 2 : 3 + ($random(seed) & 3);
            p_val = t == 6 ? 0 : $random(seed) & 3;
            w = 14'(t << 11 | p_val << 9 | m_val);
            host_link_model_inst.send(w, 14, 3 + ($random(seed) & 3));
            apb(1'b0, ADDR_SHIFT, 32'h0);
            `CHK(rd, 32'(w))
            apb(1'b0, ADDR_CFG, 32'h0);
            `CHK(rd, 32'(exp_cfg))
            host_link_model_inst.set_strobe(1'b1, 4);
            host_link_model_inst.set_strobe(1'b0, 4);
            exp_cfg = w;
            apb(1'b0, ADDR_CFG, 32'h0);
            `CHK(rd, 32'(exp_cfg))
            if (t == 6) begin
                // run low clears every divider, so the bypass counts start from zero
                apb(1'b1, ADDR_CTRL, 32'h0);
                repeat (3) @(posedge clk);
                `CHK({synth_out, loop_div_out, ref_clock_div}, 3'h0)
                apb(1'b1, ADDR_CTRL, 32'h1);
                {c0, c1, b} = {syn_chg, mon_rise, 8'($random(seed))};
                host_link_model_inst.send(14'(b), 8, 4);
                repeat (8) @(posedge clk);
                `CHK(syn_chg - c0, 8)
                `CHK(mon_rise - c1, 4)
            end else if (t < 2 || t == 5) begin
                `CHK(monitor_out, 1'(t == 1))
            end else begin
                measure(3);
                `CHK(per, t == 2 ? 64 : t == 3 ? 4 * m_val : nd(p_val) * (t == 7 ? 16 : 4))
            end
        end
        // monitor select is 111 and the shift register full here
        pload($random(seed), $random(seed), $random(seed), $random(seed), 1'b1);
        give_verdict();
    end
endmodule : tb_synth_divider_config_logic
`default_nettype wire
